// *** hdl/bidirectional_dual_fifo_mailbox.sv ***
`timescale 1ns/1ns
module bidirectional_dual_fifo_mailbox (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // port a pins
  input wire logic port_a_clock,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_enable,
  input wire logic port_a_write_select,
  input wire logic port_a_mailbox_select,
  input wire logic port_a_offset_program,
  input wire logic [1:0] port_a_offset_select,
  input wire logic [bififo_pkg::DATA_W-1:0] port_a_data_bus_in,
  output logic [bififo_pkg::DATA_W-1:0] port_a_data_bus_out,
  output logic port_a_data_bus_oe,
  output logic a_input_ready,
  output logic a_output_ready,
  output logic a_almost_empty_n,
  output logic a_almost_full_n,
  output logic ab_mailbox_flag_n,
  // port b pins
  input wire logic port_b_clock,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_enable,
  input wire logic port_b_write_select,
  input wire logic port_b_mailbox_select,
  input wire logic [bififo_pkg::DATA_W-1:0] port_b_data_bus_in,
  output logic [bififo_pkg::DATA_W-1:0] port_b_data_bus_out,
  output logic port_b_data_bus_oe,
  output logic b_input_ready,
  output logic b_output_ready,
  output logic b_almost_empty_n,
  output logic b_almost_full_n,
  output logic ba_mailbox_flag_n
);
  // index 0 is port a / a_to_b_queue, index 1 is port b / b_to_a_queue
  // ==================================================
  // pin synchronisers
  bififo_pkg::port_in_s in_raw [2];
  bififo_pkg::port_in_s in_s1_ff [2];
  bififo_pkg::port_in_s in_ff [2];
  logic [2:0] pclk_ff [2];
  logic edge_w [2];
  logic sel [2];

  assign in_raw[0] = '{port_a_chip_select_n, port_a_enable, port_a_write_select,
    port_a_mailbox_select, port_a_offset_program, port_a_offset_select, port_a_data_bus_in};
  assign in_raw[1] = '{port_b_chip_select_n, port_b_enable, port_b_write_select,
    port_b_mailbox_select, 1'b0, 2'h0, port_b_data_bus_in};

  // port clocks are sampled; their rising edge becomes a one-cycle enable
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      pclk_ff[p] <= {pclk_ff[p][1:0], (p == 0) ? port_a_clock : port_b_clock};
      in_s1_ff[p] <= in_raw[p];
      in_ff[p] <= in_s1_ff[p];
    end
  end

  // the pins' data rides the same two-stage path as the clock, so they stay aligned
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      edge_w[p] = pclk_ff[p][1] & ~pclk_ff[p][2];
      sel[p] = edge_w[p] & ~in_ff[p].cs_n & in_ff[p].en;
    end
  end

  // ==================================================
  // offsets
  logic [bififo_pkg::OFF_W-1:0] off_ff [4];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        off_ff[i] <= bififo_pkg::OFF_RESET;
      end
    end else if (sel[0] && in_ff[0].write && in_ff[0].prog) begin
      off_ff[in_ff[0].osel] <= in_ff[0].data[bififo_pkg::OFF_W-1:0];
    end
  end

  // ==================================================
  // per direction: queue, input buffer, flags, mailbox
  logic [bififo_pkg::DATA_W-1:0] mem_ff [2][bififo_pkg::DEPTH];
  logic [bififo_pkg::PTR_W-1:0] wptr_ff [2];
  logic [bififo_pkg::PTR_W-1:0] rptr_ff [2];
  logic [bififo_pkg::DATA_W-1:0] buf_ff [2][bififo_pkg::BUF_DEPTH];
  logic [1:0] bc_ff [2];
  logic [bififo_pkg::DATA_W-1:0] outreg_ff [2];
  logic or_ff [2];
  logic [1:0] ir_s_ff [2];
  logic [1:0] af_s_ff [2];
  logic [1:0] ne_s_ff [2];
  logic [1:0] ae_s_ff [2];
  logic [bififo_pkg::DATA_W-1:0] mail_ff [2];
  logic mflag_ff [2];
  logic [bififo_pkg::PTR_W-1:0] count [2];
  logic [bififo_pkg::PTR_W-1:0] wbin [2];
  logic [bififo_pkg::PTR_W-1:0] rbin [2];
  logic empty [2];
  logic mem_full [2];
  logic in_ok [2];
  logic push [2];
  logic pop [2];
  logic rd_fifo [2];
  logic load [2];
  logic mb_wr [2];
  logic mb_rd [2];

  always_comb begin
    for (int d = 0; d < 2; d++) begin
      // gray pointers decoded once, for addressing and occupancy alike
      wbin[d] = bififo_pkg::gray2bin(wptr_ff[d]);
      rbin[d] = bififo_pkg::gray2bin(rptr_ff[d]);
      count[d] = wbin[d] - rbin[d];
      empty[d] = (wptr_ff[d] == rptr_ff[d]);
      mem_full[d] = (count[d] == bififo_pkg::DEPTH_CNT);
      // words held in the input buffer count as occupied, so it can never overrun
      in_ok[d] = (bc_ff[d] != bififo_pkg::BUF_FULL_CNT) &&
                 ((count[d] + {7'h0, bc_ff[d]}) < bififo_pkg::DEPTH_CNT);
      push[d] = sel[d] & in_ff[d].write & ~in_ff[d].mbx & ~in_ff[d].prog &
                ir_s_ff[d][1] & in_ok[d];
      pop[d] = (bc_ff[d] != 2'h0) & ~mem_full[d];
      rd_fifo[d] = sel[1-d] & ~in_ff[1-d].write & ~in_ff[1-d].mbx;
      // stale synced not-empty is double-checked against the true pointers
      load[d] = edge_w[1-d] & ne_s_ff[d][1] & ~empty[d] & (~or_ff[d] | rd_fifo[d]);
      mb_wr[d] = sel[d] & in_ff[d].write & in_ff[d].mbx & mflag_ff[d];
      mb_rd[d] = sel[1-d] & ~in_ff[1-d].write & in_ff[1-d].mbx;
    end
  end

  // two-entry input buffer: holds a write until it is moved into the queue, one cycle unless the queue is full
  always_ff @(posedge clk) begin
    for (int d = 0; d < 2; d++) begin
      if (reset) begin
        bc_ff[d] <= 2'h0;
      end else begin
        bc_ff[d] <= bc_ff[d] + {1'b0, push[d]} - {1'b0, pop[d]};
        if (pop[d]) begin
          buf_ff[d][0] <= buf_ff[d][1];
        end
        if (push[d]) begin
          buf_ff[d][bc_ff[d][0] ^ pop[d]] <= in_ff[d].data;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int d = 0; d < 2; d++) begin
      if (reset) begin
        wptr_ff[d] <= '0;
      end else if (pop[d]) begin
        mem_ff[d][wbin[d][bififo_pkg::ADDR_W-1:0]] <= buf_ff[d][0];
        wptr_ff[d] <= bififo_pkg::bin2gray(wbin[d] + 9'h001);
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int d = 0; d < 2; d++) begin
      if (reset) begin
        rptr_ff[d] <= '0;
        or_ff[d] <= 1'b0;
        outreg_ff[d] <= '0;
      end else if (load[d]) begin
        outreg_ff[d] <= mem_ff[d][rbin[d][bififo_pkg::ADDR_W-1:0]];
        rptr_ff[d] <= bififo_pkg::bin2gray(rbin[d] + 9'h001);
        or_ff[d] <= 1'b1;
      end else if (rd_fifo[d]) begin
        or_ff[d] <= 1'b0;
      end
    end
  end

  // flags pass two stages stepped by the owning port's clock edge
  always_ff @(posedge clk) begin
    for (int d = 0; d < 2; d++) begin
      if (reset) begin
        ir_s_ff[d] <= 2'h0;
        af_s_ff[d] <= 2'h0;
        ne_s_ff[d] <= 2'h0;
        ae_s_ff[d] <= 2'h0;
      end else begin
        if (edge_w[d]) begin
          ir_s_ff[d] <= {ir_s_ff[d][0], in_ok[d]};
          af_s_ff[d] <= {af_s_ff[d][0], ((bififo_pkg::DEPTH_CNT - count[d]) >
                         off_ff[2+d])};
        end
        if (edge_w[1-d]) begin
          ne_s_ff[d] <= {ne_s_ff[d][0], ~empty[d]};
          ae_s_ff[d] <= {ae_s_ff[d][0], (count[d] > off_ff[d])};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int d = 0; d < 2; d++) begin
      if (reset) begin
        mflag_ff[d] <= 1'b1;
        mail_ff[d] <= '0;
      end else if (mb_wr[d]) begin
        mail_ff[d] <= in_ff[d].data;
        mflag_ff[d] <= 1'b0;
      end else if (mb_rd[d]) begin
        mflag_ff[d] <= 1'b1;
      end
    end
  end

  // ==================================================
  // data bus drive
  logic [bififo_pkg::DATA_W-1:0] dout_ff [2];
  logic oe_ff [2];

  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (reset) begin
        dout_ff[p] <= '0;
        oe_ff[p] <= 1'b0;
      end else begin
        dout_ff[p] <= in_ff[p].mbx ? mail_ff[1-p] : outreg_ff[1-p];
        oe_ff[p] <= ~in_ff[p].cs_n & ~in_ff[p].write;
      end
    end
  end

  assign port_a_data_bus_out = dout_ff[0];
  assign port_b_data_bus_out = dout_ff[1];
  assign port_a_data_bus_oe = oe_ff[0];
  assign port_b_data_bus_oe = oe_ff[1];
  assign a_input_ready = ir_s_ff[0][1];
  assign b_input_ready = ir_s_ff[1][1];
  assign a_output_ready = or_ff[1];
  assign b_output_ready = or_ff[0];
  assign a_almost_empty_n = ae_s_ff[1][1];
  assign b_almost_empty_n = ae_s_ff[0][1];
  assign a_almost_full_n = af_s_ff[0][1];
  assign b_almost_full_n = af_s_ff[1][1];
  assign ab_mailbox_flag_n = mflag_ff[0];
  assign ba_mailbox_flag_n = mflag_ff[1];

  // ==================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  for (genvar d = 0; d < 2; d++) begin : g_chk
    queue_bound_a: assert property (count[d] <= bififo_pkg::DEPTH_CNT)
      else $error("queue occupancy above depth");
    empty_read_a: assert property (empty[d] |=> $stable(rptr_ff[d]))
      else $error("read pointer moved on empty queue");
    mbox_block_a: assert property (!mflag_ff[d] && !mb_rd[d] |=> $stable(mail_ff[d]))
      else $error("mailbox overwritten while flagged");
    mbox_flag_a: assert property (mb_wr[d] |=> !mflag_ff[d])
      else $error("mailbox flag not lowered by write");
    ir_block_a: assert property (!ir_s_ff[d][1] |=> bc_ff[d] <= $past(bc_ff[d]))
      else $error("write accepted while input not ready");
    or_load_a: assert property ($rose(or_ff[d]) |-> $past(ne_s_ff[d][1] && edge_w[1-d]))
      else $error("output ready rose without synced data");
    ae_step_a: assert property ($changed(ae_s_ff[d][1]) |-> $past(edge_w[1-d]))
      else $error("almost-empty moved off reader edge");
    af_step_a: assert property ($changed(af_s_ff[d][1]) |-> $past(edge_w[d]))
      else $error("almost-full moved off writer edge");
  end

  offset_src_a: assert property (
    $changed(off_ff[bififo_pkg::OFF_BA_FULL]) |-> $past(sel[0] && in_ff[0].prog))
    else $error("offset changed without port a program");
  oe_cs_a: assert property (oe_ff[0] |-> $past(!in_ff[0].cs_n))
    else $error("port a drives with chip select high");
endmodule : bidirectional_dual_fifo_mailbox

// *** hdl/bififo_pkg.sv ***
package bififo_pkg;
  // ==================================================
  // geometry (256-word variant)
  localparam int DATA_W = 36;
  localparam int DEPTH = 256;
  localparam int PTR_W = 9;
  localparam int ADDR_W = 8;
  localparam int OFF_W = 9;
  localparam logic [PTR_W-1:0] DEPTH_CNT = 9'h100;
  localparam int SYNC_STAGES = 2;
  // ==================================================
  // offset slots and reset values
  localparam logic [1:0] OFF_AB_EMPTY = 2'h0;
  localparam logic [1:0] OFF_BA_EMPTY = 2'h1;
  localparam logic [1:0] OFF_AB_FULL = 2'h2;
  localparam logic [1:0] OFF_BA_FULL = 2'h3;
  localparam logic [OFF_W-1:0] OFF_RESET = 9'h008;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL_CNT = 2'h2;
  // ==================================================
  // one port's pin inputs as sampled together
  typedef struct packed {
    logic cs_n;
    logic en;
    logic write;
    logic mbx;
    logic prog;
    logic [1:0] osel;
    logic [DATA_W-1:0] data;
  } port_in_s;

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction : gray2bin
endpackage : bififo_pkg

// *** tb/port_host.sv ***
`timescale 1ns/1ns
// ==================================================
// host on one port: free-running port clock, one transfer per call
module port_host #(
  parameter int HALF = 5
) (
  // system clock
  input wire logic clk,
  // port pins
  output logic pclk,
  output logic cs_n,
  output logic en,
  output logic wr,
  output logic mbx,
  output logic prog,
  output logic [1:0] osel,
  output logic [bififo_pkg::DATA_W-1:0] bus_in,
  input wire logic [bififo_pkg::DATA_W-1:0] bus_out,
  input wire logic bus_oe
);
  logic [7:0] cnt = 8'h00;
  logic drive = 1'b0;
  logic [bififo_pkg::DATA_W-1:0] hd = '0;
  initial begin
    cs_n <= 1'b1;
    en <= 1'b0;
    wr <= 1'b0;
    mbx <= 1'b0;
    prog <= 1'b0;
    osel <= 2'h0;
  end
  always @(posedge clk) cnt <= (cnt == 8'(2 * HALF - 1)) ? 8'h00 : cnt + 8'h01;
  assign pclk = cnt < 8'(HALF);
  // a released bus shows bus_out while bus_oe is high, else the inverse of hd, so a stale word never reads as good
  assign bus_in = drive ? hd : (bus_oe ? bus_out : ~hd);
  // pins change at the port clock fall and hold half a period past the rise
  task automatic xfer(input logic c, w, m, p, input logic [1:0] s,
      input logic [bififo_pkg::DATA_W-1:0] d, output logic [bififo_pkg::DATA_W-1:0] q);
    @(posedge clk);
    while (cnt != 8'(HALF - 1)) @(posedge clk);
    cs_n <= c;
    en <= 1'b1;
    wr <= w;
    mbx <= m;
    prog <= p;
    osel <= s;
    hd <= d;
    drive <= w;
    while (cnt != 8'(2 * HALF - 1)) @(posedge clk);
    q = bus_out;
    @(posedge clk);
    while (cnt != 8'(HALF - 1)) @(posedge clk);
    cs_n <= 1'b1;
    en <= 1'b0;
    drive <= 1'b0;
  endtask : xfer
endmodule : port_host

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  localparam int W = bififo_pkg::DATA_W;
  logic clk = 1'b0;
  logic reset = 1'b1;
  int fails = 0;
  int n_compared = 0;
  logic a_clk, a_cs_n, a_en, a_wr, a_mbx, a_prog, b_clk, b_cs_n, b_en, b_wr, b_mbx;
  logic [1:0] a_osel;
  logic [W-1:0] a_din, a_dout, b_din, b_dout;
  logic a_oe, b_oe, a_ir, a_or, a_ae_n, a_af_n, ab_mf_n, b_ir, b_or, b_ae_n, b_af_n, ba_mf_n;
  always #5 clk = ~clk;
  // ==================================================
  // hosts and device
  port_host #(.HALF(5)) ha (.clk(clk), .pclk(a_clk), .cs_n(a_cs_n), .en(a_en), .wr(a_wr),
    .mbx(a_mbx), .prog(a_prog), .osel(a_osel), .bus_in(a_din), .bus_out(a_dout), .bus_oe(a_oe));
  port_host #(.HALF(6)) hb (.clk(clk), .pclk(b_clk), .cs_n(b_cs_n), .en(b_en), .wr(b_wr),
    .mbx(b_mbx), .prog(), .osel(), .bus_in(b_din), .bus_out(b_dout), .bus_oe(b_oe));
  bidirectional_dual_fifo_mailbox DUT (.clk(clk), .reset(reset), .port_a_clock(a_clk),
    .port_a_chip_select_n(a_cs_n), .port_a_enable(a_en), .port_a_write_select(a_wr),
    .port_a_mailbox_select(a_mbx), .port_a_offset_program(a_prog),
    .port_a_offset_select(a_osel), .port_a_data_bus_in(a_din), .port_a_data_bus_out(a_dout),
    .port_a_data_bus_oe(a_oe), .a_input_ready(a_ir), .a_output_ready(a_or),
    .a_almost_empty_n(a_ae_n), .a_almost_full_n(a_af_n), .ab_mailbox_flag_n(ab_mf_n),
    .port_b_clock(b_clk), .port_b_chip_select_n(b_cs_n), .port_b_enable(b_en),
    .port_b_write_select(b_wr), .port_b_mailbox_select(b_mbx), .port_b_data_bus_in(b_din),
    .port_b_data_bus_out(b_dout), .port_b_data_bus_oe(b_oe), .b_input_ready(b_ir),
    .b_output_ready(b_or), .b_almost_empty_n(b_ae_n), .b_almost_full_n(b_af_n),
    .ba_mailbox_flag_n(ba_mf_n));
  // ==================================================
  // tasks
  task automatic check(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic xf(input bit pb, input logic w, m, p, input logic [1:0] s,
      input logic [W-1:0] d, output logic [W-1:0] q);
    if (pb) hb.xfer(1'b0, w, m, p, s, d, q);
    else ha.xfer(1'b0, w, m, p, s, d, q);
  endtask : xf
  task automatic rd(input bit pb, input logic m, input logic [W-1:0] exp);
    logic [W-1:0] q;
    for (int k = 0; k < 300 && !m && (pb ? b_or : a_or) !== 1'b1; k++) @(posedge clk);
    xf(pb, 1'b0, m, 1'b0, 2'h0, '0, q);
    check("read data", exp, q);
  endtask : rd
  task automatic wr(input bit pb, input logic m, input logic [W-1:0] d);
    logic [W-1:0] q;
    xf(pb, 1'b1, m, 1'b0, 2'h0, d, q);
  endtask : wr
  // flags step on port edges only, so give both port clocks several periods
  task automatic settle;
    repeat (60) @(posedge clk);
  endtask : settle
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    finish_test();
  end
  // ==================================================
  // tests
  initial begin
    logic [W-1:0] q;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check("input ready at reset", '0, W'(a_ir));
    check("mail flag at reset", W'(1'b1), W'(ab_mf_n));
    settle();
    check("a input ready", W'(1'b1), W'(a_ir));
    check("b input ready", W'(1'b1), W'(b_ir));
    ha.xfer(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, W'(36'hdead), q);
    hb.xfer(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, '0, q);
    check("b bus enable on read", W'(1'b1), W'(b_oe));
    settle();
    check("b output ready", '0, W'(b_or));
    check("a bus enable", '0, W'(a_oe));
    for (int i = 0; i < 260; i++) wr(1'b0, 1'b0, W'(i));
    settle();
    check("a input ready full", '0, W'(a_ir));
    check("a almost full", '0, W'(a_af_n));
    // the output register holds one word beyond the queue depth
    for (int i = 0; i <= bififo_pkg::DEPTH; i++) rd(1'b1, 1'b0, W'(i));
    settle();
    check("b output ready drained", '0, W'(b_or));
    check("b almost empty", '0, W'(b_ae_n));
    fork
      for (int i = 0; i < 3; i++) wr(1'b0, 1'b0, W'(36'h100 + i));
      for (int i = 0; i < 3; i++) wr(1'b1, 1'b0, W'(36'h200 + i));
    join
    settle();
    check("a almost empty", '0, W'(a_ae_n));
    check("a output ready", W'(1'b1), W'(a_or));
    check("b output ready", W'(1'b1), W'(b_or));
    check("b almost full", W'(1'b1), W'(b_af_n));
    fork
      for (int i = 0; i < 3; i++) rd(1'b1, 1'b0, W'(36'h100 + i));
      for (int i = 0; i < 3; i++) rd(1'b0, 1'b0, W'(36'h200 + i));
    join
    for (int s = 0; s < 4; s++) begin
      xf(1'b0, 1'b1, 1'b0, 1'b1, 2'(s), (s < 2) ? W'(1'b1) : W'(9'h0ff), q);
    end
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, 1'b0, W'(36'h300 + i));
      wr(1'b1, 1'b0, W'(36'h400 + i));
    end
    settle();
    check("b almost empty offset", W'(1'b1), W'(b_ae_n));
    check("a almost empty offset", W'(1'b1), W'(a_ae_n));
    check("a almost full offset", '0, W'(a_af_n));
    check("b almost full offset", '0, W'(b_af_n));
    for (int i = 0; i < 3; i++) begin
      rd(1'b1, 1'b0, W'(36'h300 + i));
      rd(1'b0, 1'b0, W'(36'h400 + i));
    end
    wr(1'b0, 1'b1, W'(36'h5a5a));
    wr(1'b1, 1'b1, W'(36'h6b6b));
    repeat (2) @(posedge clk);
    check("ab mail flag", '0, W'(ab_mf_n));
    check("ba mail flag", '0, W'(ba_mf_n));
    wr(1'b0, 1'b1, W'(36'h1111));
    rd(1'b1, 1'b1, W'(36'h5a5a));
    rd(1'b0, 1'b1, W'(36'h6b6b));
    repeat (2) @(posedge clk);
    check("ab mail flag cleared", W'(1'b1), W'(ab_mf_n));
    check("ba mail flag cleared", W'(1'b1), W'(ba_mf_n));
    finish_test();
  end
endmodule : testbench
